// ==== hw/sub_shift_alu_pkg.sv ====
// Constants, encodings and timing counts shared by the subtract, shift and bit-set datapath.
// Assumes one clock edge per T-state and a decoder that presents one instruction per start pulse.
package sub_shift_alu_pkg;

  // ----------------------------------------------------------------
  // Operations and operand modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_SUB              = 4'h0,
    OP_SUBTRACT_BORROW  = 4'h1,
    OP_XOR              = 4'h2,
    OP_SUBTRACT_PAIR    = 4'h3,
    OP_CARRY_FORCE_ONE  = 4'h4,
    OP_BIT_SET          = 4'h5,
    OP_ARITH_LEFT       = 4'h6,
    OP_ARITH_RIGHT      = 4'h7,
    OP_LOGICAL_RIGHT    = 4'h8,
    OP_RESTART          = 4'h9
  } op_type;

  typedef enum logic [1:0] {
    MODE_REG = 2'h0,
    MODE_IMM = 2'h1,
    MODE_PTR = 2'h2,
    MODE_IDX = 2'h3
  } mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_type;

  // ----------------------------------------------------------------
  // Register and pair codes
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_PTR = 2'h2;
  localparam logic [1:0] PAIR_STACK = 2'h3;

  // ----------------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------------
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;
  localparam int HALF_BIT8 = 4;
  localparam int HALF_BIT16 = 12;

  // ----------------------------------------------------------------
  // T-state totals and memory access points
  // ----------------------------------------------------------------
  localparam logic [4:0] T_REG = 5'h04;
  localparam logic [4:0] T_MEM = 5'h07;
  localparam logic [4:0] T_IDX = 5'h13;
  localparam logic [4:0] T_PAIR = 5'h0F;
  localparam logic [4:0] T_CB_REG = 5'h08;
  localparam logic [4:0] T_RMW = 5'h0F;
  localparam logic [4:0] T_RMW_IDX = 5'h17;
  localparam logic [4:0] T_RESTART = 5'h0B;
  localparam logic [4:0] RD_MEM = 5'h04;
  localparam logic [4:0] RD_IDX = 5'h10;
  localparam logic [4:0] RD_RMW = 5'h08;
  localparam logic [4:0] WR_RMW = 5'h0C;
  localparam logic [4:0] RD_RMW_IDX = 5'h10;
  localparam logic [4:0] WR_RMW_IDX = 5'h14;
  localparam logic [4:0] WR_PUSH_HI = 5'h05;
  localparam logic [4:0] WR_PUSH_LO = 5'h08;
  localparam logic [7:0] RESTART_PAGE = 8'h00;

  // ----------------------------------------------------------------
  // Register port addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_FLAGS = 5'h06;
  localparam logic [4:0] ADDR_STACK_LO = 5'h08;
  localparam logic [4:0] ADDR_STACK_HI = 5'h09;
  localparam logic [4:0] ADDR_IDX1_LO = 5'h0A;
  localparam logic [4:0] ADDR_IDX1_HI = 5'h0B;
  localparam logic [4:0] ADDR_IDX2_LO = 5'h0C;
  localparam logic [4:0] ADDR_IDX2_HI = 5'h0D;
  localparam logic [4:0] ADDR_PC_LO = 5'h0E;
  localparam logic [4:0] ADDR_PC_HI = 5'h0F;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

endpackage

// ==== hw/sub_shift_alu.sv ====
// Execution datapath for subtract, subtract with borrow, pair subtract, carry force, bit set,
// shifts, exclusive-OR and restart call, with its own register file and memory strobes.
// Assumes memory read data arrive one clock after the read strobe and writes take one clock.
// Summary of operation
// - Restart takes eleven states, five three three.
// - Restart pushes counter high, low; jumps page zero.
// - Borrow subtract: accumulator minus source minus carry.
// - Plain subtract ignores carry, result to accumulator.
// - Subtract flags: sign, zero, half, overflow, borrow, N.
// - Source register 4, immediate/pointer 7, indexed 19.
// - Register field codes; 110 selects no register.
// - Pair subtract from pointer pair, pair codes.
// - Pair subtract 15 states, half from bit 12.
// - Carry force sets carry, clears H and N.
// - Bit field equals bit number; flags untouched.
// - Pointer memory bit set: read-modify-write, 15 states.
// - Indexed address is index plus signed displacement.
// - Register bit set 8 states, other bits kept.
// - Left shift: zero into bit 0, bit 7 carry.
// - Arithmetic right shift keeps bit 7, bit 0 carry.
// - Logical right shift clears bit 7, bit 0 carry.
// - Shift flags: sign, zero, parity; clear H, N.
// - Shift operand register 8, pointer 15, indexed 23.
// - Exclusive-OR source with accumulator into accumulator.
// - Exclusive-OR flags: S, Z, parity, H set, N C clear.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module sub_shift_alu (
  input logic i_clk,
  input logic i_nrst,
  input logic i_start,
  input sub_shift_alu_pkg::op_type i_op,
  input sub_shift_alu_pkg::mode_type i_mode,
  input logic [2:0] i_reg_sel,
  input logic [1:0] i_pair_sel,
  input logic [2:0] i_bit_sel,
  input logic i_index_sel,
  input logic [7:0] i_imm,
  input logic [7:0] i_disp,
  input logic [2:0] i_rst_vec,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_rd,
  output logic o_mem_wr,
  input logic [7:0] i_mem_rdata,
  input logic [4:0] i_addr,
  input logic [7:0] i_wdata,
  input logic i_wr,
  input logic i_rd,
  output logic [7:0] o_rdata
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic nrst_meta_q;
  logic nrst_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      nrst_meta_q <= 1'b0;
      nrst_q <= 1'b0;
    end else begin
      nrst_meta_q <= 1'b1;
      nrst_q <= nrst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  sub_shift_alu_pkg::state_type state_q;
  sub_shift_alu_pkg::op_type op_q;
  sub_shift_alu_pkg::mode_type mode_q;
  logic [4:0] tcnt_q;
  logic [2:0] sel_q;
  logic [1:0] pair_q;
  logic [2:0] bit_q;
  logic [7:0] imm_q;
  logic [2:0] vec_q;
  logic [7:0] operand_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;

  logic [7:0] gpr_q [0:7];
  logic [7:0] flags_q;
  logic [15:0] stack_q;
  logic [15:0] idx1_q;
  logic [15:0] idx2_q;
  logic [15:0] pc_q;

  wire idle = (state_q == sub_shift_alu_pkg::ST_IDLE);
  wire run = (state_q == sub_shift_alu_pkg::ST_RUN);
  wire start = idle & i_start;

  // Register code 110 names the pointer-pair memory byte, never a register.
  wire start_ptr = (i_mode == sub_shift_alu_pkg::MODE_REG) && (i_reg_sel == sub_shift_alu_pkg::REG_MEM);
  wire [15:0] ptr_pair = {gpr_q[sub_shift_alu_pkg::REG_H], gpr_q[sub_shift_alu_pkg::REG_L]};
  wire [15:0] index_base = i_index_sel ? idx2_q : idx1_q;
  wire [15:0] index_addr = index_base + {{8{i_disp[7]}}, i_disp};
  wire [15:0] start_addr = (i_op == sub_shift_alu_pkg::OP_RESTART) ? (stack_q - 16'h0001) :
                           (i_mode == sub_shift_alu_pkg::MODE_IDX) ? index_addr : ptr_pair;
  wire sub_mode_d = start_ptr ? 1'b1 : 1'b0;

  // ----------------------------------------------------------------
  // Instruction length and memory access points
  // ----------------------------------------------------------------
  wire is_acc_op = (op_q == sub_shift_alu_pkg::OP_SUB) || (op_q == sub_shift_alu_pkg::OP_SUBTRACT_BORROW) ||
                   (op_q == sub_shift_alu_pkg::OP_XOR);
  wire is_cb_op = (op_q == sub_shift_alu_pkg::OP_BIT_SET) || (op_q == sub_shift_alu_pkg::OP_ARITH_LEFT) ||
                  (op_q == sub_shift_alu_pkg::OP_ARITH_RIGHT) || (op_q == sub_shift_alu_pkg::OP_LOGICAL_RIGHT);
  wire mem_ptr = (mode_q == sub_shift_alu_pkg::MODE_PTR);
  wire mem_idx = (mode_q == sub_shift_alu_pkg::MODE_IDX);
  wire mem_op = (is_acc_op | is_cb_op) & (mem_ptr | mem_idx);

  wire [4:0] acc_total = mem_idx ? sub_shift_alu_pkg::T_IDX :
                         (mem_ptr || mode_q == sub_shift_alu_pkg::MODE_IMM) ? sub_shift_alu_pkg::T_MEM :
                         sub_shift_alu_pkg::T_REG;
  wire [4:0] cb_total = mem_idx ? sub_shift_alu_pkg::T_RMW_IDX :
                        mem_ptr ? sub_shift_alu_pkg::T_RMW : sub_shift_alu_pkg::T_CB_REG;
  wire [4:0] total = is_acc_op ? acc_total :
                     is_cb_op ? cb_total :
                     (op_q == sub_shift_alu_pkg::OP_SUBTRACT_PAIR) ? sub_shift_alu_pkg::T_PAIR :
                     (op_q == sub_shift_alu_pkg::OP_RESTART) ? sub_shift_alu_pkg::T_RESTART :
                     sub_shift_alu_pkg::T_REG;
  wire [4:0] rd_point = is_acc_op ? (mem_idx ? sub_shift_alu_pkg::RD_IDX : sub_shift_alu_pkg::RD_MEM) :
                        (mem_idx ? sub_shift_alu_pkg::RD_RMW_IDX : sub_shift_alu_pkg::RD_RMW);
  wire [4:0] wr_point = mem_idx ? sub_shift_alu_pkg::WR_RMW_IDX : sub_shift_alu_pkg::WR_RMW;
  wire last = run & (tcnt_q == total - 5'h01);
  wire is_rst = (op_q == sub_shift_alu_pkg::OP_RESTART);

  wire rd_now = run & mem_op & (tcnt_q == rd_point);
  wire capture_now = run & mem_op & (tcnt_q == rd_point + 5'h01);
  wire rmw_wr_now = run & mem_op & is_cb_op & (tcnt_q == wr_point);
  wire push_hi_now = run & is_rst & (tcnt_q == sub_shift_alu_pkg::WR_PUSH_HI);
  wire push_lo_now = run & is_rst & (tcnt_q == sub_shift_alu_pkg::WR_PUSH_LO);
  wire wr_now = rmw_wr_now | push_hi_now | push_lo_now;

  // ----------------------------------------------------------------
  // Operand selection and arithmetic
  // ----------------------------------------------------------------
  wire [7:0] acc = gpr_q[sub_shift_alu_pkg::REG_A];
  wire [7:0] src8 = (mode_q == sub_shift_alu_pkg::MODE_REG) ? gpr_q[sel_q] :
                    (mode_q == sub_shift_alu_pkg::MODE_IMM) ? imm_q : operand_q;
  wire carry_in = flags_q[sub_shift_alu_pkg::FLAG_C];
  wire cin8 = (op_q == sub_shift_alu_pkg::OP_SUBTRACT_BORROW) & carry_in;
  wire [8:0] diff8 = {1'b0, acc} - {1'b0, src8} - {8'h00, cin8};
  wire [4:0] half8 = {1'b0, acc[3:0]} - {1'b0, src8[3:0]} - {4'h0, cin8};
  wire ovf8 = (acc[7] ^ src8[7]) & (acc[7] ^ diff8[7]);

  wire [15:0] pair_val = (pair_q == sub_shift_alu_pkg::PAIR_BC) ? {gpr_q[sub_shift_alu_pkg::REG_B],
                           gpr_q[sub_shift_alu_pkg::REG_C]} :
                         (pair_q == sub_shift_alu_pkg::PAIR_DE) ? {gpr_q[sub_shift_alu_pkg::REG_D],
                           gpr_q[sub_shift_alu_pkg::REG_E]} :
                         (pair_q == sub_shift_alu_pkg::PAIR_PTR) ? ptr_pair : stack_q;
  wire [16:0] diff16 = {1'b0, ptr_pair} - {1'b0, pair_val} - {16'h0000, carry_in};
  wire [12:0] half16 = {1'b0, ptr_pair[11:0]} - {1'b0, pair_val[11:0]} - {12'h000, carry_in};
  wire ovf16 = (ptr_pair[15] ^ pair_val[15]) & (ptr_pair[15] ^ diff16[15]);

  wire [7:0] bit_mask = 8'h01 << bit_q;
  wire [7:0] res8 = (op_q == sub_shift_alu_pkg::OP_XOR) ? (acc ^ src8) :
                    (op_q == sub_shift_alu_pkg::OP_BIT_SET) ? (src8 | bit_mask) :
                    (op_q == sub_shift_alu_pkg::OP_ARITH_LEFT) ? {src8[6:0], 1'b0} :
                    (op_q == sub_shift_alu_pkg::OP_ARITH_RIGHT) ? {src8[7], src8[7:1]} :
                    (op_q == sub_shift_alu_pkg::OP_LOGICAL_RIGHT) ? {1'b0, src8[7:1]} :
                    diff8[7:0];
  wire shift_carry = (op_q == sub_shift_alu_pkg::OP_ARITH_LEFT) ? src8[7] : src8[0];

  // ----------------------------------------------------------------
  // Flag results
  // ----------------------------------------------------------------
  logic [7:0] flags_new;
  always_comb begin
    flags_new = flags_q;
    case (op_q)
      sub_shift_alu_pkg::OP_SUB, sub_shift_alu_pkg::OP_SUBTRACT_BORROW: begin
        flags_new[sub_shift_alu_pkg::FLAG_S] = diff8[7];
        flags_new[sub_shift_alu_pkg::FLAG_Z] = (diff8[7:0] == 8'h00);
        flags_new[sub_shift_alu_pkg::FLAG_H] = half8[sub_shift_alu_pkg::HALF_BIT8];
        flags_new[sub_shift_alu_pkg::FLAG_PV] = ovf8;
        flags_new[sub_shift_alu_pkg::FLAG_N] = 1'b1;
        flags_new[sub_shift_alu_pkg::FLAG_C] = diff8[8];
      end
      sub_shift_alu_pkg::OP_SUBTRACT_PAIR: begin
        flags_new[sub_shift_alu_pkg::FLAG_S] = diff16[15];
        flags_new[sub_shift_alu_pkg::FLAG_Z] = (diff16[15:0] == 16'h0000);
        flags_new[sub_shift_alu_pkg::FLAG_H] = half16[sub_shift_alu_pkg::HALF_BIT16];
        flags_new[sub_shift_alu_pkg::FLAG_PV] = ovf16;
        flags_new[sub_shift_alu_pkg::FLAG_N] = 1'b1;
        flags_new[sub_shift_alu_pkg::FLAG_C] = diff16[16];
      end
      sub_shift_alu_pkg::OP_XOR: begin
        flags_new[sub_shift_alu_pkg::FLAG_S] = res8[7];
        flags_new[sub_shift_alu_pkg::FLAG_Z] = (res8 == 8'h00);
        flags_new[sub_shift_alu_pkg::FLAG_H] = 1'b1;
        flags_new[sub_shift_alu_pkg::FLAG_PV] = ~^res8;
        flags_new[sub_shift_alu_pkg::FLAG_N] = 1'b0;
        flags_new[sub_shift_alu_pkg::FLAG_C] = 1'b0;
      end
      sub_shift_alu_pkg::OP_CARRY_FORCE_ONE: begin
        flags_new[sub_shift_alu_pkg::FLAG_H] = 1'b0;
        flags_new[sub_shift_alu_pkg::FLAG_N] = 1'b0;
        flags_new[sub_shift_alu_pkg::FLAG_C] = 1'b1;
      end
      sub_shift_alu_pkg::OP_ARITH_LEFT, sub_shift_alu_pkg::OP_ARITH_RIGHT,
      sub_shift_alu_pkg::OP_LOGICAL_RIGHT: begin
        flags_new[sub_shift_alu_pkg::FLAG_S] = res8[7];
        flags_new[sub_shift_alu_pkg::FLAG_Z] = (res8 == 8'h00);
        flags_new[sub_shift_alu_pkg::FLAG_H] = 1'b0;
        flags_new[sub_shift_alu_pkg::FLAG_PV] = ~^res8;
        flags_new[sub_shift_alu_pkg::FLAG_N] = 1'b0;
        flags_new[sub_shift_alu_pkg::FLAG_C] = shift_carry;
      end
      default: begin
        flags_new = flags_q;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  // Software writes are taken only while idle, so an instruction never sees its operands move.
  wire bus_wr = i_wr & idle;
  wire acc_wb = last & is_acc_op;
  wire cb_reg_wb = last & is_cb_op & (mode_q == sub_shift_alu_pkg::MODE_REG);
  wire pair_wb = last & (op_q == sub_shift_alu_pkg::OP_SUBTRACT_PAIR);
  wire flag_wb = last & ~is_rst & (op_q != sub_shift_alu_pkg::OP_BIT_SET);
  wire [7:0] status_byte = {7'h00, run};
  wire [7:0] rd_mux = (i_addr < sub_shift_alu_pkg::ADDR_STACK_LO) ?
                        ((i_addr == sub_shift_alu_pkg::ADDR_FLAGS) ? flags_q : gpr_q[i_addr[2:0]]) :
                      (i_addr == sub_shift_alu_pkg::ADDR_STACK_LO) ? stack_q[7:0] :
                      (i_addr == sub_shift_alu_pkg::ADDR_STACK_HI) ? stack_q[15:8] :
                      (i_addr == sub_shift_alu_pkg::ADDR_IDX1_LO) ? idx1_q[7:0] :
                      (i_addr == sub_shift_alu_pkg::ADDR_IDX1_HI) ? idx1_q[15:8] :
                      (i_addr == sub_shift_alu_pkg::ADDR_IDX2_LO) ? idx2_q[7:0] :
                      (i_addr == sub_shift_alu_pkg::ADDR_IDX2_HI) ? idx2_q[15:8] :
                      (i_addr == sub_shift_alu_pkg::ADDR_PC_LO) ? pc_q[7:0] :
                      (i_addr == sub_shift_alu_pkg::ADDR_PC_HI) ? pc_q[15:8] :
                      (i_addr == sub_shift_alu_pkg::ADDR_STATUS) ? status_byte : 8'h00;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge nrst_q) begin
    if (!nrst_q) begin
      state_q <= sub_shift_alu_pkg::ST_IDLE;
      tcnt_q <= 5'h00;
    end else begin
      case (state_q)
        sub_shift_alu_pkg::ST_IDLE: begin
          tcnt_q <= 5'h00;
          if (i_start) begin
            state_q <= sub_shift_alu_pkg::ST_RUN;
          end
        end
        sub_shift_alu_pkg::ST_RUN: begin
          tcnt_q <= tcnt_q + 5'h01;
          if (last) begin
            state_q <= sub_shift_alu_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= sub_shift_alu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge nrst_q) begin
    if (!nrst_q) begin
      op_q <= sub_shift_alu_pkg::OP_SUB;
      mode_q <= sub_shift_alu_pkg::MODE_REG;
      sel_q <= 3'h0;
      pair_q <= 2'h0;
      bit_q <= 3'h0;
      imm_q <= sub_shift_alu_pkg::RESET_BYTE;
      vec_q <= 3'h0;
    end else if (start) begin
      op_q <= i_op;
      mode_q <= sub_mode_d ? sub_shift_alu_pkg::MODE_PTR : i_mode;
      sel_q <= i_reg_sel;
      pair_q <= i_pair_sel;
      bit_q <= i_bit_sel;
      imm_q <= i_imm;
      vec_q <= i_rst_vec;
    end
  end

  // ----------------------------------------------------------------
  // Memory interface
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge nrst_q) begin
    if (!nrst_q) begin
      addr_q <= sub_shift_alu_pkg::RESET_WORD;
      wdata_q <= sub_shift_alu_pkg::RESET_BYTE;
      operand_q <= sub_shift_alu_pkg::RESET_BYTE;
    end else begin
      if (start) begin
        addr_q <= start_addr;
        wdata_q <= pc_q[15:8];
      end else if (push_hi_now) begin
        addr_q <= stack_q - 16'h0002;
        wdata_q <= pc_q[7:0];
      end else if (capture_now) begin
        operand_q <= i_mem_rdata;
      end else if (run & is_cb_op & (tcnt_q == wr_point - 5'h01)) begin
        wdata_q <= res8;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gen_gpr
      wire bus_hit = bus_wr & (i_addr == 5'(gi));
      wire exe_hit = (acc_wb & (gi == sub_shift_alu_pkg::REG_A)) | (cb_reg_wb & (sel_q == 3'(gi)));
      wire pair_hi = pair_wb & (gi == sub_shift_alu_pkg::REG_H);
      wire pair_lo = pair_wb & (gi == sub_shift_alu_pkg::REG_L);
      if (gi == sub_shift_alu_pkg::REG_MEM) begin : gen_flags
        always_ff @(posedge i_clk or negedge nrst_q) begin
          if (!nrst_q) begin
            flags_q <= sub_shift_alu_pkg::RESET_BYTE;
          end else if (flag_wb) begin
            flags_q <= flags_new;
          end else if (bus_hit) begin
            flags_q <= i_wdata;
          end
        end
        assign gpr_q[gi] = sub_shift_alu_pkg::RESET_BYTE;
      end else begin : gen_reg
        always_ff @(posedge i_clk or negedge nrst_q) begin
          if (!nrst_q) begin
            gpr_q[gi] <= sub_shift_alu_pkg::RESET_BYTE;
          end else if (exe_hit) begin
            gpr_q[gi] <= res8;
          end else if (pair_hi) begin
            gpr_q[gi] <= diff16[15:8];
          end else if (pair_lo) begin
            gpr_q[gi] <= diff16[7:0];
          end else if (bus_hit) begin
            gpr_q[gi] <= i_wdata;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge nrst_q) begin
    if (!nrst_q) begin
      stack_q <= sub_shift_alu_pkg::RESET_WORD;
      idx1_q <= sub_shift_alu_pkg::RESET_WORD;
      idx2_q <= sub_shift_alu_pkg::RESET_WORD;
      pc_q <= sub_shift_alu_pkg::RESET_WORD;
    end else if (last & is_rst) begin
      stack_q <= stack_q - 16'h0002;
      pc_q <= {sub_shift_alu_pkg::RESTART_PAGE, 2'b00, vec_q, 3'b000};
    end else if (bus_wr) begin
      if (i_addr == sub_shift_alu_pkg::ADDR_STACK_LO) stack_q[7:0] <= i_wdata;
      if (i_addr == sub_shift_alu_pkg::ADDR_STACK_HI) stack_q[15:8] <= i_wdata;
      if (i_addr == sub_shift_alu_pkg::ADDR_IDX1_LO) idx1_q[7:0] <= i_wdata;
      if (i_addr == sub_shift_alu_pkg::ADDR_IDX1_HI) idx1_q[15:8] <= i_wdata;
      if (i_addr == sub_shift_alu_pkg::ADDR_IDX2_LO) idx2_q[7:0] <= i_wdata;
      if (i_addr == sub_shift_alu_pkg::ADDR_IDX2_HI) idx2_q[15:8] <= i_wdata;
      if (i_addr == sub_shift_alu_pkg::ADDR_PC_LO) pc_q[7:0] <= i_wdata;
      if (i_addr == sub_shift_alu_pkg::ADDR_PC_HI) pc_q[15:8] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge nrst_q) begin
    if (!nrst_q) begin
      rdata_q <= sub_shift_alu_pkg::RESET_BYTE;
    end else begin
      rdata_q <= i_rd ? rd_mux : sub_shift_alu_pkg::RESET_BYTE;
    end
  end

  assign o_busy = run;
  assign o_done = last;
  assign o_mem_addr = addr_q;
  assign o_mem_wdata = wdata_q;
  assign o_mem_rd = rd_now;
  assign o_mem_wr = wr_now;
  assign o_rdata = rdata_q;

endmodule // sub_shift_alu

// ==== tb/ext_mem_model.sv ====
// External memory model: 256 bytes on address bits 7..0.
// Data stand only in the cycle after a read strobe.
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic i_clk,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata = 8'h00
);
  logic [7:0] ram [256];
  // Outside the answer cycle the lines flip, so a late sample cannot pass by luck.
  always @(posedge i_clk) begin
    if (i_wr) ram[i_addr[7:0]] <= i_wdata;
    o_rdata <= i_rd ? ram[i_addr[7:0]] : ~o_rdata;
  end
endmodule // ext_mem_model

// ==== tb/sub_shift_alu_sva.sv ====
// Checks lengths, push order and memory write-back values.
// Bound to sub_shift_alu; sees its ports only.
`timescale 1ns/1ps
module sub_shift_alu_sva (
  input wire logic i_clk, i_nrst, i_start, o_busy, o_done, o_mem_rd, o_mem_wr,
  input wire sub_shift_alu_pkg::op_type i_op,
  input wire sub_shift_alu_pkg::mode_type i_mode,
  input wire logic [2:0] i_reg_sel, i_bit_sel,
  input wire logic [15:0] o_mem_addr,
  input wire logic [7:0] o_mem_wdata, i_mem_rdata
);
  logic [3:0] op_q;
  logic [1:0] md_q;
  logic [2:0] b_q;
  logic [4:0] n_q;
  logic rd_q;
  logic [7:0] d_q;
  wire rmw = op_q > 4'h4 && op_q < 4'h9;
  wire [4:0] t_cb = md_q == 2'h0 ? 5'h08 : md_q == 2'h3 ? 5'h17 : 5'h0F;
  wire [4:0] t_acc = md_q == 2'h0 ? 5'h04 : md_q == 2'h3 ? 5'h13 : 5'h07;
  wire [4:0] len = op_q == 4'h9 ? 5'h0B : op_q == 4'h3 ? 5'h0F : op_q == 4'h4 ? 5'h04 : rmw ? t_cb : t_acc;
  // Register code 110 runs as a memory operand, so it is folded into the pointer mode.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {op_q, md_q, b_q, n_q, rd_q, d_q} <= '0;
    end else begin
      rd_q <= o_mem_rd;
      d_q <= rd_q ? i_mem_rdata : d_q;
      n_q <= o_busy ? n_q + 5'h01 : 5'h01;
      if (i_start && !o_busy) begin
        {op_q, b_q} <= {i_op, i_bit_sel};
        md_q <= (i_mode == 2'h0 && i_reg_sel == 3'h6) ? 2'h2 : i_mode;
      end
    end
  end
  default clocking cb_main @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_len; o_done |-> n_q == len; endproperty
  a_len: assert property (p_len) else $error("length");
  property p_end; o_done |=> !o_done && !o_busy; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_push; $rose(o_busy) && op_q == 4'h9 |-> ##5 o_mem_wr ##3 o_mem_wr &&
    o_mem_addr == $past(o_mem_addr, 3) - 16'h0001; endproperty
  a_push: assert property (p_push) else $error("push");
  property p_rmw; o_mem_rd && rmw |-> ##4 o_mem_wr && o_mem_addr == $past(o_mem_addr, 4); endproperty
  a_rmw: assert property (p_rmw) else $error("rmw");
  property p_set; o_mem_wr && op_q == 4'h5 |-> o_mem_wdata == (d_q | 8'h01 << b_q); endproperty
  a_set: assert property (p_set) else $error("set");
  property p_sla; o_mem_wr && op_q == 4'h6 |-> o_mem_wdata == {d_q[6:0], 1'b0}; endproperty
  a_sla: assert property (p_sla) else $error("sla");
  property p_sra; o_mem_wr && op_q == 4'h7 |-> o_mem_wdata == {d_q[7], d_q[7:1]}; endproperty
  a_sra: assert property (p_sra) else $error("sra");
  property p_srl; o_mem_wr && op_q == 4'h8 |-> o_mem_wdata == {1'b0, d_q[7:1]}; endproperty
  a_srl: assert property (p_srl) else $error("srl");
  c_push: cover property (o_mem_wr && op_q == 4'h9);
  c_idx: cover property (o_done && md_q == 2'h3);
  c_set: cover property (o_mem_wr && op_q == 4'h5);
endmodule // sub_shift_alu_sva
bind sub_shift_alu sub_shift_alu_sva chk (.*);

// ==== tb/tb_top.sv ====
// Bench: register port tasks, instruction runs and expected results.
// Assumes the memory model answers one cycle after each read strobe.
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_start = 1'b0, i_index_sel = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic o_busy, o_done, o_mem_rd, o_mem_wr;
  sub_shift_alu_pkg::op_type i_op = sub_shift_alu_pkg::OP_SUB;
  sub_shift_alu_pkg::mode_type i_mode = sub_shift_alu_pkg::MODE_REG;
  logic [2:0] i_reg_sel = 3'h0, i_bit_sel = 3'h0, i_rst_vec = 3'h3;
  logic [1:0] i_pair_sel = 2'h1;
  logic [7:0] i_imm = 8'h5D, i_disp = 8'hFD, i_wdata = 8'h00, i_mem_rdata, o_mem_wdata, o_rdata;
  logic [7:0] ex [3] = '{8'h62, 8'hD8, 8'h58};
  logic [7:0] fx [3] = '{8'h01, 8'h85, 8'h01};
  logic [4:0] i_addr = 5'h00;
  logic [15:0] o_mem_addr;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  always #2 i_clk = ~i_clk;
  sub_shift_alu dut (.*);
  ext_mem_model mem (.i_clk(i_clk), .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  task automatic chk(input string s, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk("register", e, o_rdata);
  endtask
  task automatic run(input logic [3:0] op, input logic [1:0] m, input logic [2:0] r, b);
    int k;
    @(posedge i_clk) {i_start, i_reg_sel, i_bit_sel} <= {1'b1, r, b};
    i_op <= sub_shift_alu_pkg::op_type'(op);
    i_mode <= sub_shift_alu_pkg::mode_type'(m);
    @(posedge i_clk) i_start <= 1'b0;
    for (k = 0; k < 30 && o_done !== 1'b1; k++) @(posedge i_clk) #1;
    chk("done", 8'h01, {7'h00, o_done});
    @(posedge i_clk);
    $display("test op %h ends", op);
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    {mem.ram[8'h33], mem.ram[8'hFD]} = {8'h05, 8'h8F};
    wr(5'h07, 8'h16); wr(5'h04, 8'h34); wr(5'h05, 8'h33); wr(5'h06, 8'h01);
    run(4'h1, 2'h2, 3'h6, 3'h0);
    rd(5'h07, 8'h10);
    rd(5'h06, 8'h02);
    run(4'h4, 2'h0, 3'h0, 3'h0);
    rd(5'h06, 8'h01);
    wr(5'h07, 8'h29); wr(5'h02, 8'h11);
    run(4'h0, 2'h0, 3'h2, 3'h0);
    rd(5'h07, 8'h18);
    wr(5'h04, 8'h99); wr(5'h05, 8'h99); wr(5'h03, 8'h11); wr(5'h06, 8'h01);
    run(4'h3, 2'h0, 3'h0, 3'h0);
    rd(5'h05, 8'h87);
    rd(5'h06, 8'h82);
    wr(5'h07, 8'h96);
    run(4'h2, 2'h1, 3'h0, 3'h0);
    rd(5'h07, 8'hCB);
    rd(5'h06, 8'h90);
    run(4'h5, 2'h0, 3'h7, 3'h4);
    rd(5'h07, 8'hDB);
    rd(5'h06, 8'h90);
    for (int k = 0; k < 3; k++) begin
      mem.ram[8'h87] = 8'hB1;
      run(4'h6 + 4'(k), 2'h2, 3'h6, 3'h0);
      chk("memory", ex[k], mem.ram[8'h87]);
      rd(5'h06, fx[k]);
    end
    wr(5'h0A, 8'h00); wr(5'h0B, 8'h10);
    run(4'h5, 2'h3, 3'h6, 3'h4);
    chk("memory", 8'h9F, mem.ram[8'hFD]);
    wr(5'h08, 8'h00); wr(5'h09, 8'h01); wr(5'h0E, 8'hB3); wr(5'h0F, 8'h15);
    run(4'h9, 2'h0, 3'h0, 3'h0);
    rd(5'h0E, 8'h18);
    rd(5'h08, 8'hFE);
    chk("memory", 8'h15, mem.ram[8'hFF]);
    chk("memory", 8'hB3, mem.ram[8'hFE]);
    run(4'h2, 2'h3, 3'h0, 3'h0);
    rd(5'h07, 8'h44);
    rd(5'h06, 8'h14);
    conclude();
  end
endmodule // tb_top
